// ### cstt_channel.sv
// Purpose: capture channel with private 16-bit time base, sync and trigger start
// Assumes: all inputs synchronous to clk; events arrive as levels or pulses
// Notes: cascade pair formed by tying two instances through the cascade ports
//
// Overview of operation
// RULE1: counter counts every enabled clock, wraps from all ones to zero
// RULE2: each capture edge pushes the present counter into the store
// RULE3: store keeps up to four captured values before software reads
// RULE4: sync mode clears the counter on each event of the chosen source
// RULE5: trigger mode holds the counter until a source event arrives
// RULE6: source zero with trigger select clear means free running
// RULE7: nonzero source selects sync or trigger mode, bit picks which
// RULE8: source zero with trigger select set waits for software trigger
// RULE9: two channels cascade into one 32-bit capture in every mode
// RULE10: up to six clock sources select the counter advance
// RULE11: up to thirty sources feed the sync or trigger input
// RULE12: captures raise an interrupt request on configurable conditions
// RULE13: codes 1..9 compare channels, 10 capture 5, 11..15 timers
// RULE14: higher codes map captures, comparators, converter, charge unit, self
// RULE15: source code zero means not synchronised to any module
// RULE16: software never selects a channel as its own trigger
// RULE17: capture, comparator, converter, charge unit codes only for triggering; the code also lets them clear the counter in sync mode
// RULE18: each sync or trigger indication acts once, as one-cycle pulse
`timescale 1ns/1ns
`include "cstt_cfg.svh"
module cstt_channel (
    input wire logic clk, // 50 MHz channel clock
    input wire logic rstn, // async reset, active low
    input wire logic enable, // channel on
    input wire logic [`CSTT_CLK_SEL_W-1:0] clk_select, // counter clock choice
    input wire logic [`CSTT_CLK_SRC_NUM-1:0] clk_ticks, // tick levels of the clock sources
    input wire logic capture_input_pin, // external pulse input
    input wire logic [1:0] edge_mode, // 01 rise, 10 fall, 11 both, 00 off
    input wire cstt_pkg::cstt_src_t source_select, // sync or trigger source code
    input wire logic trigger_mode_select, // 1 trigger, 0 sync
    input wire logic [`CSTT_SRC_NUM-1:0] source_events, // event lines by code
    input wire logic trigger_set, // software writes one to trigger status
    input wire logic trigger_clear, // software clears trigger status
    input wire logic [`CSTT_IRQ_SEL_W-1:0] irq_every, // interrupt every n+1 captures
    input wire logic cascade_odd, // this is the upper half of a pair
    input wire logic cascade_carry_in, // low half wrapped this cycle
    input wire logic cascade_sync_in, // low half restart or hold state
    input wire logic pop, // software reads one captured value
    output cstt_pkg::cstt_count_t capture_counter, // present time base
    output cstt_pkg::cstt_count_t capture_data, // oldest captured value
    output logic capture_ready, // store holds data
    output logic capture_overflow, // a capture was lost
    output logic trigger_status, // time base released
    output logic cascade_carry_out, // wrap pulse to the upper half
    output logic cascade_sync_out, // restart pulse or hold state to the upper half
    output logic irq // one-cycle interrupt request
);
    import cstt_pkg::*;

    // ****************************************
    // source decode
    // ****************************************
    function automatic cstt_kind_t src_kind(input cstt_src_t code);
        cstt_kind_t k;
        k = CSTT_K_TRIG_ONLY; // RULE14
        if (code == `CSTT_SRC_NONE) begin
            k = CSTT_K_NONE; // RULE15
        end else if (code <= `CSTT_SRC_TMR_HI) begin
            k = CSTT_K_SYNC_OK; // RULE13
        end else if (code <= `CSTT_SRC_RSV_HI) begin
            k = CSTT_K_RSV;
        end else if (code == `CSTT_SRC_SELF) begin
            k = CSTT_K_SELF;
        end
        if (code == `CSTT_SRC_IC5) begin
            k = CSTT_K_TRIG_ONLY; // RULE13
        end
        return k;
    endfunction : src_kind

    cstt_kind_t kind;
    logic src_level;
    logic src_prev_reg;
    logic src_pulse;
    logic sync_mode;
    logic trig_mode;
    logic soft_mode;

    assign kind = src_kind(source_select);
    // self and reserved codes never fire; software must avoid them
    assign src_level = (kind == CSTT_K_SYNC_OK || kind == CSTT_K_TRIG_ONLY)
        && source_events[source_select]; // RULE11 RULE16
    assign src_pulse = src_level && !src_prev_reg; // RULE18
    assign sync_mode = (source_select != `CSTT_SRC_NONE) && !trigger_mode_select; // RULE7
    assign trig_mode = (source_select != `CSTT_SRC_NONE) && trigger_mode_select; // RULE7
    assign soft_mode = (source_select == `CSTT_SRC_NONE) && trigger_mode_select; // RULE8

    // edge detect on the selected source so a held level acts once
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            src_prev_reg <= 1'b0;
        end else begin
            src_prev_reg <= src_level; // RULE18
        end
    end

    // ****************************************
    // run control
    // ****************************************
    cstt_state_t state_reg;
    logic sync_hit;
    logic trig_hit;
    logic tick;
    logic run;

    // the upper half of a pair follows the lower half's events
    assign sync_hit = cascade_odd ? cascade_sync_in : (sync_mode && src_pulse); // RULE9
    assign trig_hit = trig_mode && src_pulse; // RULE5
    assign tick = (clk_select < `CSTT_CLK_SEL_W'(`CSTT_CLK_SRC_NUM))
        && clk_ticks[clk_select]; // RULE10
    assign run = enable && (state_reg == CSTT_RUN);
    assign trigger_status = (state_reg == CSTT_RUN) && (trig_mode || soft_mode);

    // hold until trigger in trigger modes, otherwise run at once
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= CSTT_HOLD;
        end else begin
            unique case (state_reg)
                CSTT_HOLD: begin
                    if (enable && (trig_hit || (soft_mode && trigger_set)
                        || !(trig_mode || soft_mode))) begin
                        state_reg <= CSTT_RUN; // RULE4 RULE5 RULE6 RULE8
                    end
                end
                CSTT_RUN: begin
                    // set wins over a clear in the same cycle
                    if (!enable || (trigger_clear && (trig_mode || soft_mode)
                        && !trig_hit && !trigger_set)) begin
                        state_reg <= CSTT_HOLD;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // time base
    // ****************************************
    cstt_count_t cnt_reg;
    logic advance;
    assign advance = run && (cascade_odd ? cascade_carry_in : tick); // RULE9
    assign capture_counter = cnt_reg;
    assign cascade_carry_out = advance && (cnt_reg == `CSTT_CNT_ONES);
    assign cascade_sync_out = sync_hit || (state_reg == CSTT_HOLD);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= `CSTT_CNT_ZERO;
        end else if (sync_hit || (cascade_odd && cascade_sync_in)) begin
            cnt_reg <= `CSTT_CNT_ZERO; // RULE4
        end else if (advance) begin
            cnt_reg <= cnt_reg + 1'b1; // RULE1
        end
    end

    // ****************************************
    // capture and interrupt
    // ****************************************
    cstt_fifo_if fif ();
    logic pin_prev_reg;
    logic cap_ev;
    logic [`CSTT_IRQ_SEL_W-1:0] irq_cnt_reg;
    logic irq_reg;

    assign cap_ev = run && ((edge_mode[0] && capture_input_pin && !pin_prev_reg)
        || (edge_mode[1] && !capture_input_pin && pin_prev_reg));
    assign fif.push = cap_ev; // RULE2
    assign fif.push_data = cnt_reg; // RULE2
    assign fif.pop = pop;
    assign capture_data = fif.pop_data;
    assign capture_ready = fif.not_empty;
    assign capture_overflow = fif.overflow;
    assign irq = irq_reg;

    cstt_fifo u_store (
        .clk(clk),
        .rstn(rstn),
        .fif(fif)
    );

    // pin history for edge detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= capture_input_pin;
        end
    end

    // request after every irq_every+1 captures
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_cnt_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= 1'b0;
            if (cap_ev) begin
                if (irq_cnt_reg == irq_every) begin
                    irq_cnt_reg <= '0;
                    irq_reg <= 1'b1; // RULE12
                end else begin
                    irq_cnt_reg <= irq_cnt_reg + 1'b1;
                end
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // a plain step from all ones, with no restart in the same cycle
    sequence wrap_s;
        advance && !sync_hit && !(cascade_odd && cascade_sync_in) && cnt_reg == `CSTT_CNT_ONES;
    endsequence

    // a held trigger-mode time base sees a start by a source event
    sequence trig_arm_s;
        state_reg == CSTT_HOLD && enable && trig_hit;
    endsequence

    // the software start: a set pulse while held with source zero
    sequence soft_arm_s;
        state_reg == CSTT_HOLD && enable && soft_mode && trigger_set;
    endsequence

    // running, status up unless software left the trigger modes meanwhile
    sequence running_s;
        state_reg == CSTT_RUN && (trigger_status || !(trig_mode || soft_mode));
    endsequence

    // free running and sync time base
    counter_wrap_a: assert property (@(posedge clk) disable iff (!rstn) // RULE1
        wrap_s |=> cnt_reg == `CSTT_CNT_ZERO) else $error("no wrap to zero");
    count_step_a: assert property (@(posedge clk) disable iff (!rstn) // RULE1
        advance && !sync_hit && !cascade_odd |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter did not step");
    sync_clear_a: assert property (@(posedge clk) disable iff (!rstn) // RULE4
        sync_mode && src_pulse && !cascade_odd |=> cnt_reg == `CSTT_CNT_ZERO)
        else $error("sync did not clear");
    sync_start_a: assert property (@(posedge clk) disable iff (!rstn) // RULE4 RULE7
        enable && sync_mode |=> state_reg == CSTT_RUN) else $error("sync mode held");
    free_run_a: assert property (@(posedge clk) disable iff (!rstn) // RULE6
        enable && source_select == `CSTT_SRC_NONE && !trigger_mode_select
        |=> state_reg == CSTT_RUN) else $error("free run not started");

    // trigger and software start, and the clear that stops them
    trig_hold_a: assert property (@(posedge clk) disable iff (!rstn) // RULE5
        state_reg == CSTT_HOLD |=> $stable(cnt_reg) || cnt_reg == `CSTT_CNT_ZERO)
        else $error("held counter moved");
    trig_start_a: assert property (@(posedge clk) disable iff (!rstn) // RULE5
        enable && trig_hit |=> state_reg == CSTT_RUN) else $error("trigger ignored");
    trig_status_a: assert property (@(posedge clk) disable iff (!rstn) // RULE5 RULE7
        trig_arm_s |=> running_s) else $error("trigger did not release");
    soft_start_a: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        enable && soft_mode && trigger_set |=> trigger_status || !soft_mode)
        else $error("soft trigger lost");
    soft_status_a: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        soft_arm_s |=> running_s) else $error("software start lost");
    clear_stop_a: assert property (@(posedge clk) disable iff (!rstn) // RULE5 RULE8
        state_reg == CSTT_RUN && trigger_clear && (trig_mode || soft_mode)
        && !trig_hit && !trigger_set |=> state_reg == CSTT_HOLD)
        else $error("trigger clear ignored");
    // reserved and self codes must never release a held time base
    dead_code_a: assert property (@(posedge clk) disable iff (!rstn) // RULE14 RULE16
        state_reg == CSTT_HOLD && trig_mode && (kind == CSTT_K_RSV || kind == CSTT_K_SELF)
        |=> state_reg == CSTT_HOLD) else $error("dead code released");
    pulse_once_a: assert property (@(posedge clk) disable iff (!rstn) // RULE18
        src_pulse |=> !src_pulse) else $error("event acted twice");

    // cascade: the upper half moves only with the lower half
    odd_idle_a: assert property (@(posedge clk) disable iff (!rstn) // RULE9
        cascade_odd && !cascade_carry_in && !cascade_sync_in |=> $stable(cnt_reg))
        else $error("upper half moved alone");
    // a carry steps it by one; a restart in the same cycle wins over the carry
    odd_step_a: assert property (@(posedge clk) disable iff (!rstn) // RULE9
        cascade_odd && run && cascade_carry_in && !cascade_sync_in
        |=> cnt_reg == $past(cnt_reg) + 16'h0001) else $error("upper half missed carry");
    odd_sync_a: assert property (@(posedge clk) disable iff (!rstn) // RULE9
        cascade_odd && cascade_sync_in |=> cnt_reg == `CSTT_CNT_ZERO)
        else $error("upper half not restarted");
    carry_wrap_a: assert property (@(posedge clk) disable iff (!rstn) // RULE1 RULE9
        cascade_carry_out |=> cnt_reg == `CSTT_CNT_ZERO) else $error("carry without wrap");

    // capture store and request
    capture_push_a: assert property (@(posedge clk) disable iff (!rstn) // RULE2
        cap_ev && !fif.full |=> capture_ready) else $error("capture not stored");
    // an empty store shows a fresh capture at once, so the value can be checked
    capture_value_a: assert property (@(posedge clk) disable iff (!rstn) // RULE2
        cap_ev && !fif.not_empty |=> capture_data == $past(cnt_reg))
        else $error("wrong value captured");
    // the request comes one cycle after the capture that completes the chosen count
    irq_pulse_a: assert property (@(posedge clk) disable iff (!rstn) // RULE12
        irq |-> $past(cap_ev)) else $error("irq without capture");
    irq_count_a: assert property (@(posedge clk) disable iff (!rstn) // RULE12
        cap_ev && irq_cnt_reg == irq_every |=> irq) else $error("irq count missed");
endmodule : cstt_channel

// ### cstt_cfg.svh
// Purpose: constants for the capture channel with its own time base
// Assumes: one 50 MHz clock
// Notes: offsets of source codes and field layout of the control inputs
`ifndef CSTT_CFG_SVH
`define CSTT_CFG_SVH
`define CSTT_CNT_W 16
`define CSTT_CNT_ONES 16'hFFFF
`define CSTT_CNT_ZERO 16'h0000
`define CSTT_FIFO_DEPTH 4
`define CSTT_PTR_W 2
`define CSTT_SRC_W 5
`define CSTT_SRC_NUM 32
`define CSTT_SRC_NONE 5'h00
`define CSTT_SRC_OC_LO 5'h01
`define CSTT_SRC_OC_HI 5'h09
`define CSTT_SRC_IC5 5'h0A
`define CSTT_SRC_TMR_LO 5'h0B
`define CSTT_SRC_TMR_HI 5'h0F
`define CSTT_SRC_RSV_LO 5'h10
`define CSTT_SRC_RSV_HI 5'h11
`define CSTT_SRC_IC78_LO 5'h12
`define CSTT_SRC_IC_HI 5'h17
`define CSTT_SRC_CMP_LO 5'h18
`define CSTT_SRC_CMP_HI 5'h1A
`define CSTT_SRC_ADC 5'h1B
`define CSTT_SRC_CTU 5'h1C
`define CSTT_SRC_IC6 5'h1D
`define CSTT_SRC_IC9 5'h1E
`define CSTT_SRC_SELF 5'h1F
`define CSTT_CLK_SEL_W 3
`define CSTT_CLK_SRC_NUM 6
`define CSTT_IRQ_SEL_W 2
`endif

// ### cstt_pkg.sv
// Purpose: types for the capture channel
// Assumes: cstt_cfg.svh defines the widths
// Notes: types only
`include "cstt_cfg.svh"
package cstt_pkg;
    typedef logic [`CSTT_CNT_W-1:0] cstt_count_t;
    typedef logic [`CSTT_SRC_W-1:0] cstt_src_t;
    // time base run state, gray coded along hold -> run
    typedef enum logic [1:0] {
        CSTT_HOLD = 2'b00,
        CSTT_RUN = 2'b01
    } cstt_state_t;
    // decoded kind of a source code
    typedef enum logic [2:0] {
        CSTT_K_NONE = 3'd0,
        CSTT_K_SYNC_OK = 3'd1,
        CSTT_K_TRIG_ONLY = 3'd2,
        CSTT_K_SELF = 3'd3,
        CSTT_K_RSV = 3'd4
    } cstt_kind_t;
endpackage : cstt_pkg

// ### cstt_fifo_if.sv
// Purpose: push and pop path between the channel and its capture store
// Assumes: single clock
// Notes: none
`timescale 1ns/1ns
interface cstt_fifo_if;
    import cstt_pkg::*;
    logic push;
    cstt_count_t push_data;
    logic pop;
    cstt_count_t pop_data;
    logic not_empty;
    logic full;
    logic overflow;
    modport owner (output push, push_data, pop, input pop_data, not_empty, full, overflow);
    modport store (input push, push_data, pop, output pop_data, not_empty, full, overflow);
endinterface : cstt_fifo_if

// ### cstt_fifo.sv
// Purpose: four level store of captured counter values
// Assumes: single clock, async active low reset
// Notes: a push into a full store with no pop in the same cycle is dropped and flagged
`timescale 1ns/1ns
`include "cstt_cfg.svh"
module cstt_fifo (
    input wire logic clk, // channel clock
    input wire logic rstn, // async reset, active low
    cstt_fifo_if.store fif // push and pop path
);
    import cstt_pkg::*;
    cstt_count_t mem_reg [`CSTT_FIFO_DEPTH];
    logic [`CSTT_PTR_W-1:0] wr_reg;
    logic [`CSTT_PTR_W-1:0] rd_reg;
    logic [`CSTT_PTR_W:0] cnt_reg;
    logic do_push;
    logic do_pop;
    logic ovf_reg;

    assign fif.not_empty = (cnt_reg != '0);
    assign fif.full = (cnt_reg == (`CSTT_PTR_W+1)'(`CSTT_FIFO_DEPTH));
    assign do_pop = fif.pop && fif.not_empty;
    // a pop frees a slot in the same cycle, so push with pop on full is kept
    assign do_push = fif.push && (!fif.full || do_pop);
    assign fif.overflow = ovf_reg;
    assign fif.pop_data = mem_reg[rd_reg];

    // storage
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_reg[wr_reg] <= fif.push_data; // RULE3
        end
    end

    // pointers and fill level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (`CSTT_PTR_W+1)'(do_push) - (`CSTT_PTR_W+1)'(do_pop);
        end
    end

    // overflow flag, set wins over the clear by pop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ovf_reg <= 1'b0;
        end else if (fif.push && !do_push) begin
            ovf_reg <= 1'b1;
        end else if (do_pop) begin
            ovf_reg <= 1'b0;
        end
    end

    fill_bound_a: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        cnt_reg <= (`CSTT_PTR_W+1)'(`CSTT_FIFO_DEPTH)) else $error("store overfilled");
    full_drop_a: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        fif.full && fif.push && !fif.pop |=> ovf_reg && fif.full) else $error("full push kept");
endmodule : cstt_fifo

// ### cstt_far_end.sv
// Purpose: far side model, capture pulse line and on-chip event sources
// Assumes: driven on the falling edge of clk
// Notes: lines fall back to low between pulses, as real event lines do
`timescale 1ns/1ns
`include "cstt_cfg.svh"
module cstt_far_end (
    input wire logic clk, // channel clock
    output logic pin, // capture pulse line
    output logic [`CSTT_SRC_NUM-1:0] events // one line per source code
);
    // idle low so a stale level never looks like a fresh event
    initial begin
        pin = 1'b0;
        events = '0;
    end
    // one pulse, wide enough that both of its edges are sampled
    task automatic pulse_pin();
        @(negedge clk) pin = 1'b1;
        repeat (2) @(negedge clk);
        pin = 1'b0;
        repeat (3) @(negedge clk);
    endtask : pulse_pin
    // raise one source line for len cycles; only its rise is an event
    task automatic fire(input int code, input int len);
        @(negedge clk) events[code] = 1'b1;
        repeat (len) @(negedge clk);
        events[code] = 1'b0;
    endtask : fire
endmodule : cstt_far_end

// ### capture_sync_trigger_timebase_bench.sv
// Purpose: self-checking bench for the capture channel
// Assumes: counter held still while capturing, so the stored value is known
// Notes: the wrap run costs about 65k cycles
`timescale 1ns/1ns
`include "cstt_cfg.svh"
module capture_sync_trigger_timebase_bench;
    import cstt_pkg::*;
    logic clk, rstn, enable, trig_mode, trig_set, trig_clr, pop, pin, ready, ovf;
    logic status, carry, sync_out, irq, casc_odd, casc_carry, casc_sync;
    logic [2:0] clk_sel;
    logic [5:0] ticks;
    logic [1:0] edge_mode, irq_every;
    logic [31:0] events;
    cstt_src_t src;
    cstt_count_t counter, data;
    int fail_count, checks_done, seed, model_cnt, irq_seen, carry_seen, i, base, cap_count;
    int q[$];
    int codes[6] = '{18, 0, 16, 17, 31, 10};
    bit frees[6] = '{1, 1, 0, 0, 0, 1};
    cstt_channel cstt_channel_inst (.clk(clk), .rstn(rstn), .enable(enable),
        .clk_select(clk_sel), .clk_ticks(ticks), .capture_input_pin(pin),
        .edge_mode(edge_mode), .source_select(src), .trigger_mode_select(trig_mode),
        .source_events(events), .trigger_set(trig_set), .trigger_clear(trig_clr),
        .irq_every(irq_every), .cascade_odd(casc_odd), .cascade_carry_in(casc_carry),
        .cascade_sync_in(casc_sync), .pop(pop), .capture_counter(counter),
        .capture_data(data), .capture_ready(ready), .capture_overflow(ovf),
        .trigger_status(status), .cascade_carry_out(carry),
        .cascade_sync_out(sync_out), .irq(irq));
    cstt_far_end cstt_far_end_inst (.clk(clk), .pin(pin), .events(events));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // one-cycle pulses are counted where they stand
    always @(posedge clk) begin
        if (irq === 1'b1) irq_seen++;
        if (carry === 1'b1) carry_seen++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic do_reset();
        @(negedge clk) rstn = 1'b0;
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        model_cnt = 0;
        q.delete();
    endtask : do_reset
    // k selected ticks; the other sources toggle at random to expose a bad select
    task automatic tick(input int k);
        repeat (k) begin
            @(negedge clk);
            ticks = 6'($random(seed));
            if (clk_sel < 3'd6) ticks[clk_sel] = 1'b1;
        end
        @(negedge clk) ticks = '0;
        if (clk_sel < 3'd6) model_cnt = (model_cnt + k) & 'hFFFF;
    endtask : tick
    // a capture with the counter frozen; each enabled edge stores once, a full store drops
    task automatic cap(input logic [1:0] mode);
        edge_mode = mode;
        cap_count += int'(mode[0]) + int'(mode[1]);
        repeat (int'(mode[0]) + int'(mode[1])) begin
            if (q.size() < `CSTT_FIFO_DEPTH) q.push_back(model_cnt);
        end
        cstt_far_end_inst.pulse_pin();
    endtask : cap
    // watchdog, some 20k cycles past the expected run, yet short of the run limit
    initial begin
        #(20 * 90000);
        fail_count++;
        end_of_test();
    end
    //********************************************************
    // main sequence
    //********************************************************
    initial begin
        seed = 63;
        {rstn, trig_mode, trig_set, trig_clr, pop, ticks, clk_sel, src} = '0;
        {casc_odd, casc_carry, casc_sync} = '0;
        enable = 1'b1;
        edge_mode = 2'b01;
        irq_every = 2'b00;
        fail_count = 0;
        checks_done = 0;
        do_reset();
        check(counter, 0);
        check(ready, 0);
        check(status, 0);
        check(sync_out, 0);
        for (i = 0; i < 8; i++) begin
            clk_sel = i[2:0];
            tick(1 + ($random(seed) & 15));
            check(counter, model_cnt);
        end
        clk_sel = 3'd2;
        carry_seen = 0;
        tick(65536 - model_cnt + 3);
        check(counter, model_cnt);
        check(carry_seen, 1);
        irq_seen = 0;
        cap_count = 0;
        irq_every = 2'($random(seed));
        // edge modes off, rise, fall, both, rise: five captures into four places
        for (i = 0; i < 5; i++) begin
            if (i == 4) check(ovf, 0);
            tick(1 + ($random(seed) & 7));
            cap((i < 4) ? 2'(i) : 2'b01);
        end
        check(irq_seen, cap_count / (irq_every + 1));
        check(ovf, 1);
        while (q.size() > 0) begin
            check(ready, 1);
            check(data, q.pop_front());
            @(negedge clk) pop = 1'b1;
            @(negedge clk) pop = 1'b0;
        end
        check(ready, 0);
        check(ovf, 0);
        // upper half of a pair: own ticks ignored, lower carry steps, lower restart clears
        casc_odd = 1'b1;
        base = model_cnt;
        tick(6);
        check(counter, base);
        repeat (3) begin
            @(negedge clk) casc_carry = 1'b1;
            @(negedge clk) casc_carry = 1'b0;
        end
        check(counter, (base + 3) & 'hFFFF);
        @(negedge clk) casc_sync = 1'b1;
        @(negedge clk) casc_sync = 1'b0;
        check(counter, 0);
        casc_odd = 1'b0;
        model_cnt = 0;
        // sync sources only from codes that may synchronise
        for (i = 0; i < 4; i++) begin
            src = (i < 2) ? 5'(1 + ($random(seed) & 7)) : 5'(11 + ($random(seed) & 3));
            tick(5);
            cstt_far_end_inst.fire(src ^ 5'd1, 1);
            check(counter, model_cnt);
            fork
                cstt_far_end_inst.fire(src, 8);
                begin
                    repeat (4) @(negedge clk);
                    model_cnt = 0;
                    tick(3);
                end
            join
            check(counter, model_cnt);
        end
        // trigger codes: legal ones release the time base, others never do
        trig_mode = 1'b1;
        for (i = 0; i < 6; i++) begin
            src = 5'(codes[i]);
            do_reset();
            tick(4);
            model_cnt = 0;
            check(counter, 0);
            check(sync_out, 1);
            if (codes[i] == 0) begin
                @(negedge clk) trig_set = 1'b1;
                @(negedge clk) trig_set = 1'b0;
            end else cstt_far_end_inst.fire(codes[i], 1);
            repeat (3) @(negedge clk);
            check(status, frees[i]);
            tick(5);
            if (!frees[i]) model_cnt = 0;
            check(counter, model_cnt);
            @(negedge clk) trig_clr = 1'b1;
            @(negedge clk) trig_clr = 1'b0;
            check(status, 0);
        end
        end_of_test();
    end
endmodule : capture_sync_trigger_timebase_bench
